// file: inc/dsw_pkg.sv
// Purpose: shared constants and types for the serial write port of a 14-bit DAC
// Assumes: 100 MHz system clock; serial pins are asynchronous to it
// Notes: power mode encodings and frame layout live here
// Operation
// (R1) sixteen-bit input shift register holds frame
// (R2) first two bits select power mode
// (R3) host starts frame with sync falling
// (R4) sample data on each falling sclk
// (R5) sixteenth falling edge executes the update
// (R6) host keeps sync low sixteen edges
// (R7) sync high at least 20ns between frames
// (R8) early sync rise aborts the frame
// (R9) abort clears shift register, flags invalid
// (R10) abort keeps code and mode unchanged
// (R11) code is straight unsigned binary, 14 bits
// (R12) code ranges zero to 16383
// (R13) code selects one resistor string tap
// (R14) mode 00 normal,01 1k,10 100k,11 hi-z
// (R15) power-up clears DAC register to zero
// (R16) power-down leaves DAC register untouched
// (R17) fourteen code bits follow, msb first
// (R18) extra edges after sixteenth change nothing
package dsw_pkg;
  localparam int FRAME_BITS = 16;
  localparam int CODE_BITS = 14;
  localparam int CNT_BITS = 5;
  localparam int MODE_HI_POS = 15;
  localparam int MODE_LO_POS = 14;
  localparam logic [13:0] CODE_RESET = 14'h0000;
  localparam logic [13:0] CODE_MAX = 14'h3FFF;
  localparam logic [15:0] SHIFT_RESET = 16'h0000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SYNC_HIGH_MIN_NS = 20;
  localparam int SYNC_HIGH_MIN_CYC = (SYNC_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    DSW_PM_NORMAL = 2'b00,
    DSW_PM_1K = 2'b01,
    DSW_PM_100K = 2'b10,
    DSW_PM_HIZ = 2'b11
  } dsw_mode_t;

  typedef struct packed {
    logic power_mode_bit_hi;
    logic power_mode_bit_lo;
    logic [13:0] code;
  } dsw_frame_t;

  typedef struct packed {
    logic amp_enable;
    logic pull_1k;
    logic pull_100k;
  } dsw_stage_t;

  localparam dsw_stage_t STAGE_RESET = 3'b100;

  function automatic dsw_stage_t dsw_stage(input dsw_mode_t m);
    dsw_stage_t s;
    s = 3'b000;
    case (m)
      DSW_PM_NORMAL: s.amp_enable = 1'b1;
      DSW_PM_1K: s.pull_1k = 1'b1;
      DSW_PM_100K: s.pull_100k = 1'b1;
      default: s = 3'b000;
    endcase
    return s;
  endfunction : dsw_stage
endpackage : dsw_pkg

// file: design/dsw_sync2.sv
// Purpose: two-flop synchroniser for the serial pins
// Assumes: inputs asynchronous to clk_i
// Notes: reset value chosen per bit
`timescale 1ns/1ps
module dsw_sync2 #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= RST_VAL;
      q_reg <= RST_VAL;
    end else begin
      meta_reg <= d_i;
      q_reg <= meta_reg;
    end
  end

  assign q_o = q_reg;
endmodule : dsw_sync2

// file: design/dsw_write_port.sv
// Purpose: serial write front end, holds mode and DAC code
// Assumes: sclk far slower than clk_i (125 ns bench period)
// Notes: sync high time is checked only, not enforced
`timescale 1ns/1ps
module dsw_write_port
  import dsw_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sync_n_i,
  input wire logic sclk_i,
  input wire logic sdata_i,
  output logic [13:0] dac_code_o,
  output logic [1:0] power_mode_o,
  output logic amp_enable_o,
  output logic pull_1k_o,
  output logic pull_100k_o,
  output logic update_o,
  output logic abort_o,
  output logic frame_invalid_o
);
  logic [2:0] pins;
  logic sync_n_s;
  logic sclk_s;
  logic sdata_s;

  dsw_sync2 #(.W(3), .RST_VAL(3'b110)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i({sync_n_i, sclk_i, sdata_i}),
    .q_o(pins)
  );
  assign {sync_n_s, sclk_s, sdata_s} = pins;

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DONE} dsw_state_t;

  dsw_state_t state_reg, state_next;
  logic sync_d_reg, sync_d_next;
  logic sclk_d_reg, sclk_d_next;
  logic [15:0] shift_reg, shift_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [13:0] code_reg, code_next;
  dsw_mode_t mode_reg, mode_next;
  dsw_stage_t stage_reg, stage_next;
  logic update_reg, update_next;
  logic abort_reg, abort_next;
  logic inval_reg, inval_next;
  logic sync_fall, sync_rise, sclk_fall;
  dsw_frame_t frame;

  always_comb begin
    sync_fall = sync_d_reg & ~sync_n_s;
    sync_rise = ~sync_d_reg & sync_n_s;
    sclk_fall = sclk_d_reg & ~sclk_s;
    state_next = state_reg;
    sync_d_next = sync_n_s;
    sclk_d_next = sclk_s;
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    code_next = code_reg;
    mode_next = mode_reg;
    update_next = 1'b0;
    abort_next = 1'b0;
    inval_next = inval_reg;
    frame = shift_reg;
    case (state_reg)
      ST_IDLE: begin
        if (sync_fall) begin // [R3]
          state_next = ST_SHIFT;
          cnt_next = 5'd0;
          shift_next = SHIFT_RESET;
        end
      end
      ST_SHIFT: begin
        if (sclk_fall && cnt_reg == 5'(FRAME_BITS - 1)) begin
          // last bit beats a sync rise seen in the same cycle
          frame = {shift_reg[14:0], sdata_s};
          shift_next = frame; // [R1] [R4] [R17]
          cnt_next = cnt_reg + 5'd1;
          code_next = frame.code; // [R5] [R11] [R12] [R17]
          mode_next = dsw_mode_t'({frame.power_mode_bit_hi, frame.power_mode_bit_lo}); // [R2] [R14]
          update_next = 1'b1;
          inval_next = 1'b0;
          state_next = sync_rise ? ST_IDLE : ST_DONE; // [R7]
        end else if (sync_rise) begin
          // early rise: drop frame, keep code and mode
          state_next = ST_IDLE; // [R8]
          shift_next = SHIFT_RESET; // [R9]
          inval_next = 1'b1; // [R9] [R10]
          abort_next = 1'b1;
        end else if (sclk_fall) begin
          shift_next = {shift_reg[14:0], sdata_s}; // [R1] [R4] [R17]
          cnt_next = cnt_reg + 5'd1;
        end
      end
      ST_DONE: begin
        if (sync_rise) begin // [R18] [R7]
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    stage_next = dsw_stage(mode_next); // [R14] [R16]
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      sync_d_reg <= 1'b1;
      sclk_d_reg <= 1'b1;
      shift_reg <= SHIFT_RESET;
      cnt_reg <= 5'd0;
      code_reg <= CODE_RESET; // [R15]
      mode_reg <= DSW_PM_NORMAL;
      stage_reg <= STAGE_RESET;
      update_reg <= 1'b0;
      abort_reg <= 1'b0;
      inval_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sync_d_reg <= sync_d_next;
      sclk_d_reg <= sclk_d_next;
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
      code_reg <= code_next;
      mode_reg <= mode_next;
      stage_reg <= stage_next;
      update_reg <= update_next;
      abort_reg <= abort_next;
      inval_reg <= inval_next;
    end
  end

  // code drives the tap select of the string
  assign dac_code_o = code_reg; // [R13]
  assign power_mode_o = mode_reg;
  assign amp_enable_o = stage_reg.amp_enable;
  assign pull_1k_o = stage_reg.pull_1k;
  assign pull_100k_o = stage_reg.pull_100k;
  assign update_o = update_reg;
  assign abort_o = abort_reg;
  assign frame_invalid_o = inval_reg;

  // helper: sync high time in cycles
  logic [7:0] hi_cnt_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hi_cnt_reg <= 8'd0;
    end else begin
      hi_cnt_reg <= sync_n_s ? ((hi_cnt_reg == 8'hFF) ? hi_cnt_reg : hi_cnt_reg + 8'd1) : 8'd0;
    end
  end

  property p_abort_keeps;
    @(posedge clk_i) disable iff (!rst_n_i)
      abort_o |-> $stable(dac_code_o) && $stable(power_mode_o);
  endproperty
  a_abort_keeps: assert property (p_abort_keeps) else $error("abort changed code or mode"); // [R10]

  property p_abort_cause;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_reg == ST_SHIFT && sync_rise && !(sclk_fall && cnt_reg == 5'd15))
        |=> abort_o && frame_invalid_o && shift_reg == 16'h0000;
  endproperty
  a_abort_cause: assert property (p_abort_cause) else $error("early sync rise not aborted"); // [R8] [R9]

  property p_late_rise;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_reg == ST_SHIFT && sync_rise && sclk_fall && cnt_reg == 5'd15)
        |=> update_o && !abort_o && state_reg == ST_IDLE;
  endproperty
  a_late_rise: assert property (p_late_rise) else $error("last bit lost to sync rise"); // [R5] [R7]

  property p_update_16;
    @(posedge clk_i) disable iff (!rst_n_i)
      $rose(update_o) |-> $past(cnt_reg) == 5'd15;
  endproperty
  a_update_16: assert property (p_update_16) else $error("update not on sixteenth edge"); // [R5]

  property p_code_only_on_update;
    @(posedge clk_i) disable iff (!rst_n_i)
      !update_o |-> $stable(dac_code_o) && $stable(power_mode_o);
  endproperty
  a_code_only_on_update: assert property (p_code_only_on_update) else $error("code changed without update"); // [R15] [R18]

  property p_code_from_shift;
    @(posedge clk_i) disable iff (!rst_n_i)
      update_o |-> dac_code_o == shift_reg[13:0] && power_mode_o == shift_reg[15:14];
  endproperty
  a_code_from_shift: assert property (p_code_from_shift) else $error("loaded code differs from frame"); // [R17] [R2]

  property p_stage_decode;
    @(posedge clk_i) disable iff (!rst_n_i)
      update_o |=> amp_enable_o == (power_mode_o == 2'b00) && pull_1k_o == (power_mode_o == 2'b01)
        && pull_100k_o == (power_mode_o == 2'b10);
  endproperty
  a_stage_decode: assert property (p_stage_decode) else $error("output stage decode wrong"); // [R14]

  property p_one_update;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_reg == ST_DONE && !update_o) |=> !update_o && $stable(dac_code_o) && $stable(power_mode_o);
  endproperty
  a_one_update: assert property (p_one_update) else $error("second update in frame"); // [R18]

  property p_shift_edge;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_reg == ST_SHIFT && sclk_fall && !sync_rise) |=> shift_reg[0] == $past(sdata_s);
  endproperty
  a_shift_edge: assert property (p_shift_edge) else $error("bit not sampled on falling sclk"); // [R4] [R1]

  property p_frame_start;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_reg == ST_IDLE && sync_fall && hi_cnt_reg >= 8'(SYNC_HIGH_MIN_CYC)) |=> state_reg == ST_SHIFT;
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("sync fall did not start frame"); // [R3] [R7]

  c_update: cover property (@(posedge clk_i) disable iff (!rst_n_i) update_o);
  c_abort: cover property (@(posedge clk_i) disable iff (!rst_n_i) abort_o);
  c_hiz: cover property (@(posedge clk_i) disable iff (!rst_n_i) update_o && power_mode_o == 2'b11);
  c_full: cover property (@(posedge clk_i) disable iff (!rst_n_i) update_o && dac_code_o == CODE_MAX);
endmodule : dsw_write_port

// file: testbench/dsw_host_model.sv
// Purpose: host side model driving serial write frames
// Assumes: 125 ns serial clock, idle high, stands still between frames
// Notes: data line shows the inverted last bit outside a frame
`timescale 1ns/1ps
module dsw_host_model (
  output logic sync_n_o,
  output logic sclk_o,
  output logic sdata_o
);
  initial begin
    sync_n_o = 1'b1;
    sclk_o = 1'b1;
    sdata_o = 1'b0;
  end

  // n bits msb first from w, then sync high long enough for a new frame
  // quick raises sync together with the last falling edge
  task automatic send(input logic [19:0] w, input int n, input bit quick = 1'b0);
    sync_n_o <= 1'b0;
    for (int i = 0; i < n; i++) begin
      sdata_o <= w[19-i];
      #62.5 sclk_o <= 1'b0;
      if (quick && i == n - 1) begin
        sync_n_o <= 1'b1;
      end
      #62.5 sclk_o <= 1'b1;
    end
    sdata_o <= ~sdata_o;
    #62.5 sync_n_o <= 1'b1;
    #100 sync_n_o <= 1'b1;
  endtask : send
endmodule : dsw_host_model

// file: testbench/dsw_write_port_tb_top.sv
// Purpose: self-checking bench for the serial write port
// Assumes: host model drives the pins asynchronously to clk_i
// Notes: expected code, mode and invalid flag kept in the bench
`timescale 1ns/1ps
module dsw_write_port_tb_top;
  import dsw_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sync_n, sclk, sdata, update_o, abort_o, frame_invalid_o, amp_enable_o, pull_1k_o, pull_100k_o;
  logic [13:0] dac_code_o;
  logic [1:0] power_mode_o;
  logic [31:0] rng = 32'hDD7059D5;
  logic [13:0] exp_code = 14'h0000;
  logic [1:0] exp_mode = 2'b00;
  logic exp_inv = 1'b0;
  int error_cnt = 0;
  int comparisons = 0;
  int upd_cnt = 0;
  int abt_cnt = 0;

  always #5 clk_i = ~clk_i;

  dsw_host_model i_dsw_host_model (.sync_n_o(sync_n), .sclk_o(sclk), .sdata_o(sdata));
  dsw_write_port i_dsw_write_port (.clk_i(clk_i), .rst_n_i(rst_n_i), .sync_n_i(sync_n), .sclk_i(sclk),
    .sdata_i(sdata), .dac_code_o(dac_code_o), .power_mode_o(power_mode_o), .amp_enable_o(amp_enable_o),
    .pull_1k_o(pull_1k_o), .pull_100k_o(pull_100k_o), .update_o(update_o), .abort_o(abort_o),
    .frame_invalid_o(frame_invalid_o));

  always @(posedge clk_i) begin
    upd_cnt += (update_o === 1'b1);
    abt_cnt += (abort_o === 1'b1);
  end

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs

  task automatic chk_code(input logic [13:0] got, input logic [13:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_code

  task automatic chk_mode(input logic [1:0] got, input logic [1:0] exp);
    chk_code({12'h000, got}, {12'h000, exp});
  endtask : chk_mode

  task automatic chk_flag(input logic got, input logic exp);
    chk_code({13'h0000, got}, {13'h0000, exp});
  endtask : chk_flag

  task automatic chk_cnt(input int got, input int exp);
    chk_code(14'(got), 14'(exp));
  endtask : chk_cnt

  task automatic check_all();
    chk_code(dac_code_o, exp_code);
    chk_mode(power_mode_o, exp_mode);
    chk_flag(amp_enable_o, exp_mode == 2'b00);
    chk_flag(pull_1k_o, exp_mode == 2'b01);
    chk_flag(pull_100k_o, exp_mode == 2'b10);
    chk_flag(frame_invalid_o, exp_inv);
  endtask : check_all

  task automatic frame(input logic [1:0] m, input logic [13:0] c, input int n, input bit quick = 1'b0);
    int u0;
    int a0;
    logic [31:0] r;
    u0 = upd_cnt;
    a0 = abt_cnt;
    r = xs();
    i_dsw_host_model.send({m, c, r[3:0]}, n, quick);
    repeat (3) @(posedge clk_i);
    if (n >= 16) begin
      exp_code = c;
      exp_mode = m;
      exp_inv = 1'b0;
    end else begin
      exp_inv = 1'b1;
    end
    chk_cnt(upd_cnt - u0, int'(n >= 16));
    chk_cnt(abt_cnt - a0, int'(n < 16));
    check_all();
  endtask : frame

  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    check_all();
    // full frames in all four modes, an abort after each
    for (int k = 0; k < 8; k++) begin
      frame(2'(k / 2), 14'(xs()), (k % 2) ? 1 + int'(xs() % 15) : 16);
    end
    frame(2'b00, CODE_MAX, 16);
    frame(2'b11, 14'(xs()), 15);
    frame(2'b01, 14'h0000, 20);
    frame(2'b10, 14'(xs()), 16, 1'b1);
    frame(2'b00, 14'h2AAA, 16);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    exp_code = CODE_RESET;
    exp_mode = 2'b00;
    exp_inv = 1'b0;
    repeat (4) @(posedge clk_i);
    check_all();
    frame(2'b01, 14'(xs()), 16);
    report_and_stop();
  end
endmodule : dsw_write_port_tb_top
